// >>> clkas_defs.svh
`ifndef CLKAS_DEFS_SVH
`define CLKAS_DEFS_SVH

// register offsets
`define CLKAS_OFS_ACTIVE      8'h80
`define CLKAS_OFS_LIVE_LOSS   8'h81
`define CLKAS_OFS_LIVE_LOCK   8'h82
`define CLKAS_OFS_STICKY_LOSS 8'h83
`define CLKAS_OFS_STICKY_LOCK 8'h84
`define CLKAS_OFS_PART_HIGH   8'h86
`define CLKAS_OFS_PART_LOWREV 8'h87
`define CLKAS_OFS_CONTROL     8'h88

// field positions
`define CLKAS_BIT_IN1_ACTIVE  0
`define CLKAS_BIT_IN2_ACTIVE  1
`define CLKAS_BIT_REF_LOSS    0
`define CLKAS_BIT_IN1_LOSS    1
`define CLKAS_BIT_IN2_LOSS    2
`define CLKAS_BIT_LOCK_LIVE   0
`define CLKAS_BIT_LOCK_STICKY 1
`define CLKAS_BIT_CAL_START   6

// reset values and constant read bits
`define CLKAS_RST_ACTIVE      8'h20
`define CLKAS_RST_STICKY_LOSS 3'h0
`define CLKAS_RST_STICKY_LOCK 1'h1
`define CLKAS_RST_RDATA       8'h00

// identity, values arbitrary
`define CLKAS_PART_ID         12'h5a3
`define CLKAS_REVISION_ID     4'h7

`endif

// >>> clkas_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module clkas_host_model (
  // clock
  input  wire logic                   mclk,
  // register port
  output var  clkas_pkg::clkas_addr_t regAddr,
  output var  clkas_pkg::clkas_byte_t regWrData,
  output var  logic                   regWrite,
  output var  logic                   regRead,
  input  wire clkas_pkg::clkas_byte_t regRdData,
  input  wire logic                   regRdValid
);
  import clkas_pkg::*;
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
  end
  // released lines show the inverse so a stale value is never taken
  task automatic writeReg(input clkas_addr_t a, input clkas_byte_t d);
    @(negedge mclk);
    regAddr   = a;
    regWrData = d;
    regWrite  = 1'b1;
    @(negedge mclk);
    regWrite  = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask : writeReg
  task automatic readReg(input clkas_addr_t a, output clkas_byte_t d, output logic v);
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    regAddr = ~a;
    v       = regRdValid;
    d       = regRdData;
  endtask : readReg
endmodule : clkas_host_model
`default_nettype wire

// >>> clkas_pkg.sv
`default_nettype none
package clkas_pkg;
  typedef logic [7:0] clkas_byte_t;
  typedef logic [7:0] clkas_addr_t;
  typedef enum logic [1:0] {
    CLKAS_CAL_IDLE  = 2'b00,
    CLKAS_CAL_START = 2'b01,
    CLKAS_CAL_WAIT  = 2'b10
  } clkas_cal_e;
endpackage : clkas_pkg
`default_nettype wire

// >>> clkas_status_bank.sv
// How it works
// - input two's active bit is 1 only while input two is selected and has no live signal loss.
// - input one's active bit is 1 only while input one is selected and has no live signal loss.
// - bit 2 of the live loss register follows input two's loss alarm.
// - bit 1 of the live loss register follows input one's loss alarm.
// - bit 0 of the live loss register follows the crystal reference loss alarm.
// - bit 0 of the live lock register reads 1 while the PLL is unlocked and 0 while locked.
// - the sticky input two loss flag at bit 2 sets while its live alarm is up and holds.
// - the sticky input one loss flag at bit 1 sets while its live alarm is up and holds.
// - the sticky reference loss flag at bit 0 sets while its live alarm is up and holds.
// - the sticky lock loss flag at bit 1 of its own register latches any lock loss.
// - writing 0 to a sticky flag bit clears that flag.
// - the interrupt output is high when the output is enabled and an unmasked flag is set.
// - writing 1 to the self-clearing calibration bit starts calibration; lock regained ends it.
`timescale 1ns/1ps
`default_nettype none
`include "clkas_defs.svh"
module clkas_status_bank (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // register port from the serial interface decoder
  input  wire clkas_pkg::clkas_addr_t regAddr,
  input  wire clkas_pkg::clkas_byte_t regWrData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output var  clkas_pkg::clkas_byte_t regRdData,
  output var  logic                  regRdValid,
  // live alarms and selection from the clock path, asynchronous
  input  wire logic                  inputTwoLossAlarm,
  input  wire logic                  inputOneLossAlarm,
  input  wire logic                  referenceLossAlarm,
  input  wire logic                  lockLossAlarm,
  input  wire logic                  inputTwoSelected,
  // interrupt control levels, same clock
  input  wire logic                  interruptOutEnable,
  input  wire logic                  inputTwoLossIrqMask,
  input  wire logic                  inputOneLossIrqMask,
  input  wire logic                  referenceLossIrqMask,
  input  wire logic                  lockLossIrqMask,
  // outputs to pins and to the PLL
  output var  logic                  interruptOut,
  output var  logic                  selfCalibrationStart,
  output var  logic                  calibrationBusy
);
  import clkas_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised live status

  logic [4:0] asyncLevels;
  logic [4:0] syncLevels;
  logic       inputTwoLossLive;
  logic       inputOneLossLive;
  logic       referenceLossLive;
  logic       lockLossLive;
  logic       inputTwoSel;

  assign asyncLevels = {inputTwoSelected, lockLossAlarm, referenceLossAlarm,
                        inputOneLossAlarm, inputTwoLossAlarm};

  clkas_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (asyncLevels),
    .syncOut (syncLevels)
  );

  assign inputTwoLossLive  = syncLevels[0];
  assign inputOneLossLive  = syncLevels[1];
  assign referenceLossLive = syncLevels[2];
  assign lockLossLive      = syncLevels[3];
  assign inputTwoSel       = syncLevels[4];

  ////////////////////////////////////////////////////////////////////////////
  // active input indicators

  logic inputTwoActiveInd_q;
  logic inputTwoActiveInd_d;
  logic inputOneActiveInd_q;
  logic inputOneActiveInd_d;

  // a lost input never reads active even while still selected
  assign inputTwoActiveInd_d = inputTwoSel & ~inputTwoLossLive;
  assign inputOneActiveInd_d = ~inputTwoSel & ~inputOneLossLive;

  always_ff @(posedge mclk) begin
    if (rst) begin
      inputTwoActiveInd_q <= 1'b0;
      inputOneActiveInd_q <= 1'b0;
    end else begin
      inputTwoActiveInd_q <= inputTwoActiveInd_d;
      inputOneActiveInd_q <= inputOneActiveInd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  logic wrStickyLoss;
  logic wrStickyLock;
  logic wrControl;

  // read-only offsets decode to nothing, so writes there vanish
  assign wrStickyLoss = regWrite & (regAddr == `CLKAS_OFS_STICKY_LOSS);
  assign wrStickyLock = regWrite & (regAddr == `CLKAS_OFS_STICKY_LOCK);
  assign wrControl    = regWrite & (regAddr == `CLKAS_OFS_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags

  // a flag clears on a written 0 unless its alarm is up in the same cycle
  function automatic logic sticky_next(input logic flag, input logic live,
                                       input logic wr, input logic wbit);
    logic keep;
    keep = flag & ~(wr & ~wbit);
    return live | keep;
  endfunction : sticky_next

  logic [2:0] stickyLoss_q;
  logic [2:0] stickyLoss_d;
  logic       lockLossSticky_q;
  logic       lockLossSticky_d;

  assign stickyLoss_d[`CLKAS_BIT_IN2_LOSS] = sticky_next(
    stickyLoss_q[`CLKAS_BIT_IN2_LOSS], inputTwoLossLive,
    wrStickyLoss, regWrData[`CLKAS_BIT_IN2_LOSS]);
  assign stickyLoss_d[`CLKAS_BIT_IN1_LOSS] = sticky_next(
    stickyLoss_q[`CLKAS_BIT_IN1_LOSS], inputOneLossLive,
    wrStickyLoss, regWrData[`CLKAS_BIT_IN1_LOSS]);
  assign stickyLoss_d[`CLKAS_BIT_REF_LOSS] = sticky_next(
    stickyLoss_q[`CLKAS_BIT_REF_LOSS], referenceLossLive,
    wrStickyLoss, regWrData[`CLKAS_BIT_REF_LOSS]);
  assign lockLossSticky_d = sticky_next(
    lockLossSticky_q, lockLossLive,
    wrStickyLock, regWrData[`CLKAS_BIT_LOCK_STICKY]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      stickyLoss_q     <= `CLKAS_RST_STICKY_LOSS;
      lockLossSticky_q <= `CLKAS_RST_STICKY_LOCK;
    end else begin
      stickyLoss_q     <= stickyLoss_d;
      lockLossSticky_q <= lockLossSticky_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output

  logic [3:0] flagVec;
  logic [3:0] maskVec;
  logic       interrupt_d;

  assign flagVec = {lockLossSticky_q, stickyLoss_q};
  assign maskVec = {lockLossIrqMask, inputTwoLossIrqMask,
                    inputOneLossIrqMask, referenceLossIrqMask};
  assign interrupt_d = interruptOutEnable & (|(flagVec & ~maskVec));

  always_ff @(posedge mclk) begin
    if (rst) begin
      interruptOut <= 1'b0;
    end else begin
      interruptOut <= interrupt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self calibration

  clkas_cal_e calState_q;
  clkas_cal_e calState_d;
  logic       calRequest;

  assign calRequest = wrControl & regWrData[`CLKAS_BIT_CAL_START];

  // the start bit is never stored, so it reads back 0 by itself
  always_comb begin
    calState_d = calState_q;
    case (calState_q)
      CLKAS_CAL_IDLE: begin
        if (calRequest) begin
          calState_d = CLKAS_CAL_START;
        end
      end
      CLKAS_CAL_START: begin
        calState_d = CLKAS_CAL_WAIT;
      end
      CLKAS_CAL_WAIT: begin
        // a fresh request wins over lock regained so no start write made while waiting is lost
        if (calRequest) begin
          calState_d = CLKAS_CAL_START;
        end else if (!lockLossLive) begin
          calState_d = CLKAS_CAL_IDLE;
        end
      end
      default: begin
        calState_d = CLKAS_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      calState_q           <= CLKAS_CAL_IDLE;
      selfCalibrationStart <= 1'b0;
      calibrationBusy      <= 1'b0;
    end else begin
      calState_q           <= calState_d;
      selfCalibrationStart <= (calState_d == CLKAS_CAL_START);
      calibrationBusy      <= (calState_d != CLKAS_CAL_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [11:0] partId;
  logic [3:0]  revId;
  clkas_byte_t activeByte;
  clkas_byte_t liveLossByte;
  clkas_byte_t liveLockByte;
  clkas_byte_t stickyLossByte;
  clkas_byte_t stickyLockByte;
  clkas_byte_t rdMux;

  assign partId = `CLKAS_PART_ID;
  assign revId  = `CLKAS_REVISION_ID;

  // reserved bit 5 of the active register reads as its reset value
  assign activeByte = `CLKAS_RST_ACTIVE
                    | {6'h00, inputTwoActiveInd_q, inputOneActiveInd_q};
  assign liveLossByte   = {5'h00, inputTwoLossLive, inputOneLossLive,
                           referenceLossLive};
  assign liveLockByte   = {7'h00, lockLossLive};
  assign stickyLossByte = {5'h00, stickyLoss_q};
  assign stickyLockByte = {6'h00, lockLossSticky_q, 1'b0};

  always_comb begin
    case (regAddr)
      `CLKAS_OFS_ACTIVE:      rdMux = activeByte;
      `CLKAS_OFS_LIVE_LOSS:   rdMux = liveLossByte;
      `CLKAS_OFS_LIVE_LOCK:   rdMux = liveLockByte;
      `CLKAS_OFS_STICKY_LOSS: rdMux = stickyLossByte;
      `CLKAS_OFS_STICKY_LOCK: rdMux = stickyLockByte;
      `CLKAS_OFS_PART_HIGH:   rdMux = partId[11:4];
      `CLKAS_OFS_PART_LOWREV: rdMux = {partId[3:0], revId};
      default:                rdMux = 8'h00;
    endcase
  end

  // read data is sampled on the strobe edge, shows one cycle later and is held until the next
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData  <= `CLKAS_RST_RDATA;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= rdMux;
      end
    end
  end
endmodule : clkas_status_bank
`default_nettype wire

// >>> clkas_status_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkas_defs.svh"
module clkas_status_bank_props (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst,
  // register port
  input wire clkas_pkg::clkas_addr_t regAddr,
  input wire clkas_pkg::clkas_byte_t regWrData,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire clkas_pkg::clkas_byte_t regRdData,
  input wire logic                   regRdValid,
  // alarms and control
  input wire logic                   inputTwoLossAlarm,
  input wire logic                   lockLossAlarm,
  input wire logic                   inputTwoSelected,
  input wire logic                   interruptOutEnable,
  // outputs
  input wire logic                   interruptOut,
  input wire logic                   selfCalibrationStart,
  input wire logic                   calibrationBusy
);
  import clkas_pkg::*;
  localparam logic [11:0] PartId = `CLKAS_PART_ID;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // alarms held four cycles, five for the sticky lock check, so the synchroniser delay has passed
  AST_IN2_ACT_OFF: assert property (
    inputTwoLossAlarm [*4] ##0 (regRead && regAddr == 8'h80) |=> !regRdData[1])
    else $error("input two active during loss");
  AST_IN1_ACT_OFF: assert property (
    inputTwoSelected [*4] ##0 (regRead && regAddr == 8'h80) |=> !regRdData[0])
    else $error("input one active while unselected");
  AST_IN2_LOSS: assert property (
    inputTwoLossAlarm [*4] ##0 (regRead && regAddr == 8'h81) |=> regRdData[2])
    else $error("live input two loss not shown");
  AST_LOCK_LIVE: assert property (
    (!lockLossAlarm) [*4] ##0 (regRead && regAddr == 8'h82) |=> regRdData == 8'h00)
    else $error("lock loss shown while locked");
  AST_LOCK_STICKY: assert property (
    lockLossAlarm [*5] ##0 (regRead && regAddr == 8'h84) |=> regRdData == 8'h02)
    else $error("lock loss flag not latched");
  AST_PART_HIGH: assert property (
    regRead && regAddr == 8'h86 |=> regRdValid && regRdData == PartId[11:4])
    else $error("part identifier high wrong");
  AST_PART_LOW: assert property (
    regRead && regAddr == 8'h87 |=> regRdData == {PartId[3:0], `CLKAS_REVISION_ID})
    else $error("part identifier low or revision wrong");
  AST_IRQ_OFF: assert property (
    !interruptOutEnable |=> !interruptOut)
    else $error("interrupt while output disabled");
  AST_CAL_START: assert property (
    regWrite && regAddr == 8'h88 && regWrData[6] && !selfCalibrationStart
      |=> selfCalibrationStart && calibrationBusy)
    else $error("calibration did not start");
  AST_CAL_PULSE: assert property (
    selfCalibrationStart |=> !selfCalibrationStart && calibrationBusy)
    else $error("calibration start not a single pulse");
endmodule : clkas_status_bank_props
bind clkas_status_bank clkas_status_bank_props props (.mclk(mclk), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .regRdValid(regRdValid), .inputTwoLossAlarm(inputTwoLossAlarm),
  .lockLossAlarm(lockLossAlarm), .inputTwoSelected(inputTwoSelected),
  .interruptOutEnable(interruptOutEnable), .interruptOut(interruptOut),
  .selfCalibrationStart(selfCalibrationStart), .calibrationBusy(calibrationBusy));
`default_nettype wire

// >>> clkas_sync.sv
`timescale 1ns/1ps
`default_nettype none
module clkas_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : clkas_sync
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkas_defs.svh"
module testbench;
  import clkas_pkg::*;
  localparam logic [11:0] PartId = `CLKAS_PART_ID;
  logic        mclk;
  logic        rst;
  clkas_addr_t regAddr;
  clkas_byte_t regWrData;
  clkas_byte_t regRdData;
  logic        regWrite;
  logic        regRead;
  logic        regRdValid;
  logic        irqEn;
  logic        irq;
  logic        calStart;
  logic        calBusy;
  logic [4:0]  alm;
  logic [3:0]  msk;
  int          badCount;
  int          checksDone;
  int          cycles;
  //////////////////////////////////////////////////////////////////////////////
  clkas_status_bank dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
    .inputTwoLossAlarm(alm[3]), .inputOneLossAlarm(alm[2]), .referenceLossAlarm(alm[1]),
    .lockLossAlarm(alm[0]), .inputTwoSelected(alm[4]), .interruptOutEnable(irqEn),
    .inputTwoLossIrqMask(msk[3]), .inputOneLossIrqMask(msk[2]),
    .referenceLossIrqMask(msk[1]), .lockLossIrqMask(msk[0]), .interruptOut(irq),
    .selfCalibrationStart(calStart), .calibrationBusy(calBusy));
  clkas_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input clkas_byte_t got, input clkas_byte_t exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rdChk(input clkas_addr_t a, input clkas_byte_t exp);
    clkas_byte_t d;
    logic        v;
    host.readReg(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask : rdChk
  task automatic finalReport();
    $display("mismatches %0d, checks %0d", badCount, checksDone);
    if (badCount == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finalReport
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // the whole sequence needs well under two thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      finalReport();
    end
  end
  initial begin
    rst = 1'b1;
    alm = 5'h00;
    msk = 4'h0;
    irqEn = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    rdChk(8'h84, 8'h02);
    rdChk(8'h83, 8'h00);
    rdChk(8'h86, PartId[11:4]);
    rdChk(8'h87, {PartId[3:0], `CLKAS_REVISION_ID});
    host.writeReg(8'h86, 8'h00);
    host.writeReg(8'h81, 8'hff);
    rdChk(8'h86, PartId[11:4]);
    rdChk(8'h81, 8'h00);
    host.writeReg(8'h84, 8'h00);
    rdChk(8'h84, 8'h00);
    for (int i = 0; i < 32; i++) begin
      alm = i[4:0];
      repeat (4) @(negedge mclk);
      rdChk(8'h80, {6'h08, alm[4] & ~alm[3], ~alm[4] & ~alm[2]});
      rdChk(8'h81, {5'h00, alm[3:1]});
      rdChk(8'h82, {7'h00, alm[0]});
    end
    alm = 5'h00;
    repeat (4) @(negedge mclk);
    rdChk(8'h83, 8'h07);
    host.writeReg(8'h83, 8'hff);
    rdChk(8'h83, 8'h07);
    host.writeReg(8'h83, 8'hfb);
    rdChk(8'h83, 8'h03);
    host.writeReg(8'h83, 8'hfc);
    rdChk(8'h83, 8'h00);
    host.writeReg(8'h84, 8'h00);
    rdChk(8'h84, 8'h00);
    // each flag alone: raise, mask, disable, clear
    for (int j = 0; j < 4; j++) begin
      irqEn = 1'b1;
      alm = 5'h01 << j;
      repeat (4) @(negedge mclk);
      alm = 5'h00;
      repeat (4) @(negedge mclk);
      check({7'h00, irq}, 8'h01);
      msk = 4'h1 << j;
      repeat (2) @(negedge mclk);
      check({7'h00, irq}, 8'h00);
      msk = ~msk;
      repeat (2) @(negedge mclk);
      check({7'h00, irq}, 8'h01);
      msk = 4'h0;
      irqEn = 1'b0;
      repeat (2) @(negedge mclk);
      check({7'h00, irq}, 8'h00);
      irqEn = 1'b1;
      if (j == 0) host.writeReg(8'h84, 8'h00);
      else host.writeReg(8'h83, ~(8'h01 << (j - 1)));
      repeat (2) @(negedge mclk);
      check({7'h00, irq}, 8'h00);
    end
    alm = 5'h01;
    host.writeReg(8'h88, 8'h40);
    check({6'h00, calStart, calBusy}, 8'h03);
    @(negedge mclk);
    check({6'h00, calStart, calBusy}, 8'h01);
    rdChk(8'h84, 8'h02);
    check({6'h00, calStart, calBusy}, 8'h01);
    // a second start while still waiting restarts the sequence
    host.writeReg(8'h88, 8'h40);
    check({6'h00, calStart, calBusy}, 8'h03);
    alm = 5'h00;
    repeat (5) @(negedge mclk);
    check({6'h00, calStart, calBusy}, 8'h00);
    rdChk(8'h88, 8'h00);
    finalReport();
  end
endmodule : testbench
`default_nettype wire
